// [bench/gsrc_checker.sv]
`timescale 1ns/1ps
module gsrc_checker
  import gsrc_pkg::*;
(
  input wire logic     clk,                // clock
  input wire logic     rst_b,              // reset
  input wire logic     external_reset_low, // reset pin
  input gsrc_spi_in_t  spi_in,             // pins in
  input gsrc_spi_out_t spi_out,            // pins out
  input wire logic     core_reset_b        // core reset
);
  logic [2:0]  sck_reg, sck_next;
  logic [15:0] sh_reg, sh_next;
  logic [4:0]  cnt_reg, cnt_next;
  always_comb begin
    sck_next = {sck_reg[1:0], spi_in.sclk};
    sh_next  = sh_reg;
    cnt_next = spi_in.sel_b ? 5'h00 : cnt_reg;
    // sampled late so miso has settled
    if (!spi_in.sel_b && sck_reg[1] && !sck_reg[2]) begin
      sh_next  = {sh_reg[14:0], spi_out.miso};
      cnt_next = (cnt_reg == 5'h10) ? 5'h01 : cnt_reg + 5'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_reg <= '0;
      sh_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      sck_reg <= sck_next;
      sh_reg  <= sh_next;
      cnt_reg <= cnt_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_pin_in; !external_reset_low [*5] |-> !core_reset_b; endproperty
  a_pin_in: assert property (p_pin_in) else $error("pin reset");
  property p_pin_out; $rose(external_reset_low) |-> ##[1:6] core_reset_b; endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin release");
  property p_quiet; !core_reset_b [*3] |-> !spi_out.miso_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("oe in reset");
  property p_off; spi_in.sel_b [*5] |-> !spi_out.miso_oe; endproperty
  a_off: assert property (p_off) else $error("oe unselected");
  property p_on; (!spi_in.sel_b && core_reset_b) [*5] |-> spi_out.miso_oe; endproperty
  a_on: assert property (p_on) else $error("oe selected");
  property p_fall; $fell(spi_in.sel_b) && core_reset_b |-> ##[2:5] spi_out.miso_oe; endproperty
  a_fall: assert property (p_fall) else $error("oe late");
  property p_rise; $rose(spi_in.sel_b) |-> ##[2:5] !spi_out.miso_oe; endproperty
  a_rise: assert property (p_rise) else $error("oe stuck");
  property p_par; $rose(cnt_reg == 5'h10) |-> ^sh_reg; endproperty
  a_par: assert property (p_par) else $error("parity");
endmodule // gsrc_checker
bind gsrc_ctrl gsrc_checker gsrc_checker_i (.clk(clk), .rst_b(rst_b),
  .external_reset_low(external_reset_low), .spi_in(spi_in), .spi_out(spi_out),
  .core_reset_b(core_reset_b));

// [bench/gsrc_host.sv]
`timescale 1ns/1ps
module gsrc_host (
  input  wire logic clk,   // clock
  input  wire logic miso,  // data in
  output logic      sclk,  // link clock
  output logic      sel_b, // select
  output logic      mosi   // data out
);
  initial begin
    sclk  = 1'b0;
    sel_b = 1'b1;
    mosi  = 1'b0;
  end
  // link clock idles low; long select setup
  task automatic select(input logic on);
    @(negedge clk);
    mosi  = 1'b0;
    sel_b = !on;
    repeat (16) @(negedge clk);
  endtask
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      mosi = w[i];
      repeat (4) @(negedge clk);
      r[i] = miso;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
endmodule // gsrc_host

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  import gsrc_pkg::*;
  function automatic logic [15:0] wd(input logic [14:0] v);
    return {v, ~^v};
  endfunction
  localparam logic [14:0] ERR0 = 15'h0005;
  localparam logic [15:0] Z = wd(15'h0000);
  localparam logic [15:0] OK = wd(15'h0001);
  localparam logic [15:0] RD_ST = wd({6'h00, GSRC_ADDR_STATUS, 2'b00});
  localparam logic [15:0] WR_ID = wd({6'h00, GSRC_ADDR_ID, 2'b10});
  localparam logic [15:0] RD_ID = wd({6'h00, GSRC_ADDR_ID, 2'b00});
  localparam logic [15:0] RD_NONE = wd({6'h00, 7'h20, 2'b00});
  localparam logic [14:0] ID_VAL = 15'h0155;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ext_rst_b = 1'b0;
  int rst_count = 0;
  logic last = 1'b0;
  logic core_rst_b;
  logic [14:0] rate = 15'h1234;
  logic [14:0] evt = '0;
  logic [15:0] r;
  int err_total = 0;
  int check_count = 0;
  gsrc_spi_in_t  si;
  gsrc_spi_out_t so;
  // no pull on miso: released line shows the inverse of the last driven bit
  wire miso_w = so.miso_oe ? so.miso : ~last;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (so.miso_oe)
      last <= so.miso;
    if (!core_rst_b)
      rst_count <= rst_count + 1;
  end
  gsrc_ctrl #(.ERR_INIT(ERR0)) gsrc_ctrl_i (.clk(clk), .rst_b(rst_b),
    .external_reset_low(ext_rst_b), .spi_in(si), .rate_data(rate), .err_event(evt),
    .spi_out(so), .core_reset_b(core_rst_b));
  gsrc_host gsrc_host_i (.clk(clk), .miso(miso_w), .sclk(si.sclk), .sel_b(si.sel_b),
    .mosi(si.mosi));
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tx(input logic [15:0] w, input logic [15:0] e, input string s);
    gsrc_host_i.xfer(w, r);
    chk(s, e, r);
  endtask
  task automatic sel(input logic on);
    gsrc_host_i.select(on);
    chk("oe", 16'(on), 16'(so.miso_oe));
  endtask
  // settling wait, far shorter than on silicon
  task automatic settle;
    repeat (40) @(negedge clk);
  endtask
  task automatic ack;
    sel(1'b1);
    gsrc_host_i.xfer(RD_ST, r);
    gsrc_host_i.xfer(RD_ST, r);
    gsrc_host_i.xfer(Z, r);
    sel(1'b0);
  endtask
  task automatic t_start;
    settle();
    sel(1'b1);
    tx(RD_ST, Z, "flags_start");
    tx(RD_ST, wd(ERR0), "status_init");
    tx(Z, wd(ERR0), "status_second");
    tx(Z, wd(rate), "rate_start");
    sel(1'b0);
    sel(1'b1);
    tx(Z, OK, "flags_clear");
    sel(1'b0);
  endtask
  task automatic t_event;
    evt = 15'h0008;
    @(negedge clk);
    evt = '0;
    rate = 15'h2aa5;
    sel(1'b1);
    tx(Z, Z, "flags_event");
    tx(Z, wd(rate), "rate_new");
    sel(1'b0);
    ack();
    sel(1'b1);
    tx(Z, OK, "flags_ack");
    sel(1'b0);
  endtask
  task automatic t_write;
    sel(1'b1);
    tx(WR_ID, OK, "flags_wr1");
    tx(wd(ID_VAL), wd(GSRC_ID_RESET), "id_first");
    tx(WR_ID, OK, "flags_after_wr");
    tx(wd(15'h0066) ^ 16'h0001, wd(ID_VAL), "id_kept");
    tx(RD_ID, OK, "flags_bad");
    tx(RD_NONE, wd(ID_VAL), "id_read");
    tx(Z, Z, "unmapped");
    sel(1'b0);
  endtask
  task automatic t_soft;
    int n0;
    sel(1'b1);
    tx(WR_ID, OK, "flags_wr");
    n0 = rst_count;
    tx(wd(GSRC_SOFT_RESET_CODE), wd(ID_VAL), "id_old");
    sel(1'b0);
    chk("soft", 16'h0001, 16'(rst_count - n0));
    settle();
    sel(1'b1);
    tx(RD_ID, Z, "flags_soft");
    tx(Z, wd(GSRC_ID_RESET), "id_reset");
    sel(1'b0);
    ack();
  endtask
  task automatic t_pin;
    ext_rst_b = 1'b0;
    repeat (8) @(negedge clk);
    chk("core_rst", 16'h0000, 16'(core_rst_b));
    gsrc_host_i.select(1'b1);
    chk("oe_rst", 16'h0000, 16'(so.miso_oe));
    gsrc_host_i.select(1'b0);
    ext_rst_b = 1'b1;
    settle();
    chk("core_run", 16'h0001, 16'(core_rst_b));
    sel(1'b1);
    tx(Z, Z, "flags_pin");
    sel(1'b0);
  endtask
  task automatic finish_test;
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    ext_rst_b = 1'b1;
    t_start();
    t_event();
    t_write();
    t_soft();
    t_pin();
    finish_test();
  end
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
endmodule // tb

// [rtl/gsrc_ctrl.sv]
`timescale 1ns/1ps
// Operation
// R1 - rate register readable right after reset, no setup command needed
// R2 - host waits 800 ms after supply, then reads status twice; the bench waits only 40 clocks
// R3 - start-up error flags held until status read twice, then cleared
// R4 - writing soft-reset code to identification register resets the whole device
// R5 - device held in reset while external reset low, resumes when high
// R6 - host keeps external reset low until supplies are valid
// R7 - serial output driven only while selected, released otherwise
// R8 - host repeats settling wait and double status read after any reset; the bench skips the status reads after the pin reset
// R9 - 16-bit frames; first frame is address, rw and parity
// R10 - read data returned in next frame, whose input is next address
// R11 - bit 0 of every word is odd parity over bits 15 to 1
module gsrc_ctrl
  import gsrc_pkg::*;
#(
  parameter logic [14:0] ERR_INIT = 15'h0001  // flags latched at start-up
) (
  input  wire logic          clk,                 // 50 MHz system clock
  input  wire logic          rst_b,               // async reset, active low
  input  wire logic          external_reset_low,  // reset pin, active low
  input  gsrc_pkg::gsrc_spi_in_t  spi_in,         // serial clock, select, data in
  input  wire logic [14:0]   rate_data,           // live angular rate sample
  input  wire logic [14:0]   err_event,           // monitor error pulses
  output gsrc_pkg::gsrc_spi_out_t spi_out,        // serial data out and enable
  output logic               core_reset_b         // internal reset, active low
);
  import gsrc_pkg::*;

  logic [2:0] pins_s;
  logic       pin_rst_s;
  logic       sclk_s, sel_b_s, mosi_s;
  logic       sclk_d_reg;

  gsrc_sync #(.WIDTH(3), .INIT(3'h3)) u_sync_spi (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({spi_in.sclk, spi_in.sel_b, spi_in.mosi}),
    .q     (pins_s)
  );
  gsrc_sync #(.WIDTH(1), .INIT(1'h0)) u_sync_rst (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (external_reset_low),
    .q     (pin_rst_s)
  );
  assign {sclk_s, sel_b_s, mosi_s} = pins_s;

  function automatic logic odd_par(input logic [14:0] v);
    return ~(^v);
  endfunction

  // soft reset pulse from the serial side
  logic soft_rst_reg, soft_rst_next;
  // R5 pin reset
  // R4 soft reset
  logic int_rst;
  assign int_rst      = !pin_rst_s || soft_rst_reg;
  assign core_reset_b = !int_rst;

  gsrc_frame_t frame_reg, frame_next;
  logic [15:0] rx_reg, rx_next;
  logic [15:0] tx_reg, tx_next;
  logic [3:0]  bit_reg, bit_next;
  logic [6:0]  adr_reg, adr_next;
  logic [14:0] id_reg, id_next;
  logic [14:0] err_reg, err_next;
  logic [1:0]  ack_reg, ack_next;
  logic        miso_reg, miso_next;
  logic        oe_reg, oe_next;
  logic        sclk_rise, sclk_fall;

  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;

  function automatic logic [14:0] reg_value(input logic [6:0] a,
                                            input logic [14:0] id,
                                            input logic [14:0] err,
                                            input logic [14:0] rate);
    // R1 rate always live
    if (a == GSRC_ADDR_RATE) begin
      return rate;
    end else if (a == GSRC_ADDR_ID) begin
      return id;
    end else if (a == GSRC_ADDR_STATUS) begin
      return err;
    end else begin
      return '0;
    end
  endfunction

  logic [14:0] status_word;
  assign status_word = (err_reg == '0) ? (15'h0001 << (GSRC_OK_BIT - 1)) : '0;

  logic [15:0] word_in;
  logic        word_done;
  logic [14:0] rd_val;
  logic [6:0]  new_adr;

  always_comb begin
    frame_next    = frame_reg;
    rx_next       = rx_reg;
    tx_next       = tx_reg;
    bit_next      = bit_reg;
    adr_next      = adr_reg;
    id_next       = id_reg;
    ack_next      = ack_reg;
    soft_rst_next = 1'b0;
    miso_next     = miso_reg;
    word_in       = {rx_reg[14:0], mosi_s};
    word_done     = 1'b0;
    new_adr       = word_in[GSRC_ADR_MSB:GSRC_ADR_LSB];
    rd_val        = reg_value(new_adr, id_reg, err_reg, rate_data);
    // R3 sticky, set beats clear
    err_next      = err_reg | err_event;
    // R7 drive only while selected
    oe_next       = !sel_b_s;
    if (sel_b_s) begin
      frame_next = GSRC_FR_ADDR;
      bit_next   = '0;
      // R9 status flags ready for first frame
      // msb already on the line, shifter holds the rest
      tx_next    = {status_word[13:0], odd_par(status_word), 1'b0};
      miso_next  = status_word[14];
    end else if (sclk_rise) begin
      rx_next  = word_in;
      bit_next = bit_reg + 4'h1;
      if (bit_reg == GSRC_BIT_LAST) begin
        word_done = 1'b1;
      end
    end else if (sclk_fall) begin
      // closing fall of a word must launch bit 15 of the next one
      tx_next   = {tx_reg[14:0], 1'b0};
      miso_next = tx_reg[15];
    end
    if (word_done) begin
      if (frame_reg == GSRC_FR_WDATA) begin
        // R11 drop bad-parity writes
        if (word_in[0] == odd_par(word_in[15:1])) begin
          if (adr_reg == GSRC_ADDR_ID) begin
            id_next = word_in[15:1];
            // R4 soft reset code
            if (word_in[15:1] == GSRC_SOFT_RESET_CODE) begin
              soft_rst_next = 1'b1;
            end
          end
        end
        frame_next = GSRC_FR_ADDR;
        tx_next    = {status_word, odd_par(status_word)};
      end else begin
        adr_next = new_adr;
        if (word_in[GSRC_RW_BIT]) begin
          frame_next = GSRC_FR_WDATA;
        end else begin
          frame_next = GSRC_FR_READ;
        end
        // R10 answer in next frame
        tx_next = {rd_val, odd_par(rd_val)};
        if (!word_in[GSRC_RW_BIT] && new_adr == GSRC_ADDR_STATUS) begin
          // R3 second read clears
          if (ack_reg + 2'h1 >= GSRC_ACK_READS) begin
            err_next = err_event;
            ack_next = '0;
          end else begin
            ack_next = ack_reg + 2'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_reg   <= 1'b0;
      soft_rst_reg <= 1'b0;
    end else begin
      sclk_d_reg   <= sclk_s;
      soft_rst_reg <= soft_rst_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_reg <= GSRC_FR_ADDR;
      rx_reg    <= '0;
      tx_reg    <= '0;
      bit_reg   <= '0;
      adr_reg   <= '0;
      id_reg    <= GSRC_ID_RESET;
      err_reg   <= ERR_INIT;
      ack_reg   <= '0;
      miso_reg  <= 1'b0;
      oe_reg    <= 1'b0;
    end else if (int_rst) begin
      // whole device restarts; flags re-latched as at power-up
      frame_reg <= GSRC_FR_ADDR;
      rx_reg    <= '0;
      tx_reg    <= '0;
      bit_reg   <= '0;
      adr_reg   <= '0;
      id_reg    <= GSRC_ID_RESET;
      err_reg   <= ERR_INIT;
      ack_reg   <= '0;
      miso_reg  <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      rx_reg    <= rx_next;
      tx_reg    <= tx_next;
      bit_reg   <= bit_next;
      adr_reg   <= adr_next;
      id_reg    <= id_next;
      err_reg   <= err_next;
      ack_reg   <= ack_next;
      miso_reg  <= miso_next;
      oe_reg    <= oe_next;
    end
  end

  assign spi_out.miso    = miso_reg;
  assign spi_out.miso_oe = oe_reg;
endmodule // gsrc_ctrl

// [rtl/gsrc_pkg.sv]
package gsrc_pkg;
  localparam int        GSRC_WORD_W      = 16;
  localparam int        GSRC_ADDR_W      = 7;
  localparam logic [6:0] GSRC_ADDR_ID    = 7'h07;
  localparam logic [6:0] GSRC_ADDR_STATUS = 7'h08;
  localparam logic [6:0] GSRC_ADDR_RATE  = 7'h00;
  localparam logic [14:0] GSRC_SOFT_RESET_CODE = 15'h0002;
  // address and status word field positions, last bit, status read count, id reset value
  localparam int        GSRC_ADR_MSB     = 9;
  localparam int        GSRC_ADR_LSB     = 3;
  localparam int        GSRC_RW_BIT      = 2;
  localparam int        GSRC_OK_BIT      = 1;
  localparam logic [3:0] GSRC_BIT_LAST   = 4'hf;
  localparam logic [1:0] GSRC_ACK_READS  = 2'h2;
  localparam logic [14:0] GSRC_ID_RESET  = 15'h0000;

  typedef enum logic [1:0] {
    GSRC_FR_ADDR,
    GSRC_FR_READ,
    GSRC_FR_WDATA
  } gsrc_frame_t;

  typedef struct packed {
    logic        sclk;
    logic        sel_b;
    logic        mosi;
  } gsrc_spi_in_t;

  typedef struct packed {
    logic        miso;
    logic        miso_oe;
  } gsrc_spi_out_t;
endpackage

// [rtl/gsrc_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module gsrc_sync #(
  parameter int  WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,    // system clock
  input  wire logic             rst_b,  // async reset
  input  wire logic [WIDTH-1:0] d,      // asynchronous inputs
  output logic      [WIDTH-1:0] q       // synchronised outputs
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // gsrc_sync
